// ===== verilog/ps2kb_pkg.sv
// Shared constants and types for the keyboard-side PS/2 link.
// Assumes a 200 MHz core clock and a separate free-running link clock.
package ps2kb_pkg;

  // Frame layout
  localparam int FRAME_BITS = 11;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] TX_LAST_BIT = 4'hA;
  localparam logic [3:0] RX_ACK_BIT = 4'hA;

  // Command and reply bytes
  localparam logic [7:0] CMD_LED = 8'hED;
  localparam logic [7:0] CMD_ECHO = 8'hEE;
  localparam logic [7:0] CMD_RATE = 8'hF3;
  localparam logic [7:0] CMD_RESEND = 8'hFE;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] REPLY_ACK = 8'hFA;

  // Values after reset
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] LAST_SCAN_RST = 8'h00;

  // Link timing: half a bit is 20 us, i.e. 25 kHz, inside the 20 to 30 kHz band
  localparam int LINK_CLK_PS = 15000;
  localparam int HALF_BIT_NS = 20000;
  localparam int IDLE_NS = 50000;
  localparam logic [11:0] HALF_BIT_CYC =
    12'((HALF_BIT_NS * 1000 + LINK_CLK_PS - 1) / LINK_CLK_PS);
  localparam logic [11:0] IDLE_CYC = 12'((IDLE_NS * 1000 + LINK_CLK_PS - 1) / LINK_CLK_PS);

  typedef struct packed {
    logic caps_lock;
    logic num_lock;
    logic scroll_lock;
  } ps2kb_led_type;

  localparam ps2kb_led_type LED_RST = '{caps_lock: 1'b0, num_lock: 1'b0, scroll_lock: 1'b0};

endpackage

// ===== verilog/ps2kb_sync.sv
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
module ps2kb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) $error("ps2kb_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ===== verilog/ps2kb_buf.sv
// Small FIFO with valid/ready on both sides; read data come from a register.
// Assumes one clock; DEPTH a power of two, default two entries.
module ps2kb_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic full_ff, nxt_full;
  logic valid_ff, nxt_valid;
  logic [WIDTH-1:0] data_ff, nxt_data;
  logic push, pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("ps2kb_buf: DEPTH must be 2^n >= 2");
    if (WIDTH < 1) $error("ps2kb_buf: WIDTH must be at least 1");
  end

  // The head word sits in data_ff; memory holds the words behind it
  assign push = in_valid && !full_ff;
  assign pop = valid_ff && out_ready;

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    nxt_valid = valid_ff;
    nxt_data = data_ff;
    if (!valid_ff || pop) begin
      if (count_ff != '0) begin
        nxt_data = mem_ff[rd_ptr_ff];
        nxt_rd_ptr = rd_ptr_ff + 1'b1;
        nxt_valid = 1'b1;
        nxt_count = count_ff - 1'b1;
      end else begin
        nxt_valid = push;
        nxt_data = push ? in_data : data_ff;
      end
    end
    if (push && !((!valid_ff || pop) && count_ff == '0)) begin
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
      nxt_count = nxt_count + 1'b1;
    end
    // Head register plus memory gives DEPTH+1 slots; stop at DEPTH to keep it honest
    nxt_full = (nxt_count + (nxt_valid ? 1'b1 : 1'b0)) >= (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (push && !((!valid_ff || pop) && count_ff == '0)) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      full_ff <= 1'b0;
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      full_ff <= nxt_full;
      valid_ff <= nxt_valid;
      data_ff <= nxt_data;
    end
  end

  assign in_ready = !full_ff;
  assign out_valid = valid_ff;
  assign out_data = data_ff;

endmodule

// ===== verilog/ps2kb_link.sv
// Keyboard end of a PS/2 link: frame engine on the link clock, command logic on core_clk.
// Assumes open-drain pins resolved outside; the host end is real logic on the far side.
module ps2kb_link #(
  parameter logic [11:0] HALF_BIT_CYC = ps2kb_pkg::HALF_BIT_CYC,
  parameter logic [11:0] IDLE_CYC = ps2kb_pkg::IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic scan_valid,
  input wire logic [7:0] scan_data,
  output logic scan_ready,
  input wire logic ps2_clk_in,
  output logic ps2_clk_out,
  output logic ps2_clk_oe,
  input wire logic ps2_data_in,
  output logic ps2_data_out,
  output logic ps2_data_oe,
  output ps2kb_pkg::ps2kb_led_type led_state,
  output logic [7:0] repeat_rate,
  output logic kbd_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Crossings

  logic [1:0] pins_s;
  logic clk_s, dat_s;
  logic tx_req_tgl_ff, tx_req_s;
  logic tx_ack_tgl_ff, tx_ack_s;
  logic rx_tgl_ff, rx_tgl_s;
  logic [7:0] tx_word_ff, rx_byte_ff;

  ps2kb_sync #(.WIDTH(2)) u_pin_sync (
    .clk(link_clk),
    .rstn(rstn),
    .async_in({ps2_clk_in, ps2_data_in}),
    .sync_out(pins_s)
  );
  assign clk_s = pins_s[1];
  assign dat_s = pins_s[0];

  ps2kb_sync #(.WIDTH(1)) u_req_sync (
    .clk(link_clk),
    .rstn(rstn),
    .async_in(tx_req_tgl_ff),
    .sync_out(tx_req_s)
  );

  ps2kb_sync #(.WIDTH(2)) u_core_sync (
    .clk(core_clk),
    .rstn(rstn),
    .async_in({tx_ack_tgl_ff, rx_tgl_ff}),
    .sync_out({tx_ack_s, rx_tgl_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link domain frame engine

  typedef enum logic [2:0] {L_IDLE, L_TX_HI, L_TX_LO, L_RX_HI, L_RX_LO} ps2kb_lstate_type;

  ps2kb_lstate_type lst_ff, nxt_lst;
  logic [11:0] tmr_ff, nxt_tmr;
  logic [3:0] bit_ff, nxt_bit;
  logic [10:0] shr_ff, nxt_shr;
  logic clk_oe_ff, nxt_clk_oe;
  logic dat_oe_ff, nxt_dat_oe;
  logic dat_out_ff, nxt_dat_out;
  logic nxt_tx_ack_tgl, nxt_rx_tgl;
  logic [7:0] nxt_rx_byte;
  logic half_done;

  // Halves shorter than the two-flop pin delay would read the wire before it settles
  initial begin
    if (HALF_BIT_CYC < 12'h004) $error("ps2kb_link: HALF_BIT_CYC must be at least 4");
    if (IDLE_CYC < 12'h004) $error("ps2kb_link: IDLE_CYC must be at least 4");
  end

  assign half_done = (tmr_ff >= HALF_BIT_CYC - 12'h001);

  always_comb begin
    nxt_lst = lst_ff;
    nxt_tmr = tmr_ff + 12'h001;
    nxt_bit = bit_ff;
    nxt_shr = shr_ff;
    nxt_clk_oe = 1'b0;
    nxt_dat_oe = 1'b0;
    nxt_dat_out = 1'b1;
    nxt_tx_ack_tgl = tx_ack_tgl_ff;
    nxt_rx_tgl = rx_tgl_ff;
    nxt_rx_byte = rx_byte_ff;
    case (lst_ff)
      L_IDLE: begin
        if (!clk_s) begin
          nxt_tmr = '0;
        end else if (!dat_s) begin
          nxt_lst = L_RX_HI;
          nxt_tmr = '0;
          nxt_bit = '0;
        end else if (tmr_ff >= IDLE_CYC && tx_req_s != tx_ack_tgl_ff) begin
          nxt_lst = L_TX_HI;
          nxt_tmr = '0;
          nxt_bit = '0;
          nxt_shr = {1'b1, ~^tx_word_ff, tx_word_ff, 1'b0};
          nxt_dat_oe = 1'b1;
          nxt_dat_out = 1'b0;
        end else if (tmr_ff >= IDLE_CYC) begin
          nxt_tmr = tmr_ff;
        end
      end
      L_TX_HI: begin
        nxt_dat_oe = 1'b1;
        nxt_dat_out = shr_ff[0];
        if (half_done) begin
          nxt_tmr = '0;
          if (!clk_s) begin
            // Host pulled clock low: drop the frame, it is sent again later
            nxt_lst = L_IDLE;
            nxt_dat_oe = 1'b0;
            nxt_dat_out = 1'b1;
          end else begin
            nxt_lst = L_TX_LO;
            nxt_clk_oe = 1'b1;
          end
        end
      end
      L_TX_LO: begin
        nxt_clk_oe = 1'b1;
        nxt_dat_oe = 1'b1;
        nxt_dat_out = shr_ff[0];
        if (half_done) begin
          nxt_tmr = '0;
          nxt_clk_oe = 1'b0;
          if (bit_ff == ps2kb_pkg::TX_LAST_BIT) begin
            nxt_lst = L_IDLE;
            nxt_dat_oe = 1'b0;
            nxt_dat_out = 1'b1;
            nxt_tx_ack_tgl = ~tx_ack_tgl_ff;
          end else begin
            nxt_lst = L_TX_HI;
            nxt_bit = bit_ff + 4'h1;
            nxt_shr = {1'b1, shr_ff[10:1]};
            nxt_dat_out = shr_ff[1];
          end
        end
      end
      L_RX_HI: begin
        nxt_dat_oe = (bit_ff == ps2kb_pkg::RX_ACK_BIT);
        nxt_dat_out = 1'b0;
        if (half_done) begin
          nxt_tmr = '0;
          nxt_lst = L_RX_LO;
          nxt_clk_oe = 1'b1;
        end
      end
      L_RX_LO: begin
        nxt_clk_oe = 1'b1;
        nxt_dat_oe = (bit_ff == ps2kb_pkg::RX_ACK_BIT);
        nxt_dat_out = 1'b0;
        if (half_done) begin
          nxt_tmr = '0;
          nxt_clk_oe = 1'b0;
          if (bit_ff == ps2kb_pkg::RX_ACK_BIT) begin
            nxt_lst = L_IDLE;
            nxt_dat_oe = 1'b0;
            nxt_dat_out = 1'b1;
            if (shr_ff[10] && (^shr_ff[9:1])) begin
              nxt_rx_byte = shr_ff[8:1];
              nxt_rx_tgl = ~rx_tgl_ff;
            end
          end else begin
            // Host moves data on our falling edge, so take it just before clock rises
            nxt_shr = {dat_s, shr_ff[10:1]};
            nxt_lst = L_RX_HI;
            nxt_bit = bit_ff + 4'h1;
            nxt_dat_oe = (nxt_bit == ps2kb_pkg::RX_ACK_BIT);
          end
        end
      end
      default: begin
        nxt_lst = L_IDLE;
        nxt_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lst_ff <= L_IDLE;
      tmr_ff <= '0;
      bit_ff <= '0;
      shr_ff <= '0;
      clk_oe_ff <= 1'b0;
      dat_oe_ff <= 1'b0;
      dat_out_ff <= 1'b1;
      tx_ack_tgl_ff <= 1'b0;
      rx_tgl_ff <= 1'b0;
      rx_byte_ff <= '0;
    end else begin
      lst_ff <= nxt_lst;
      tmr_ff <= nxt_tmr;
      bit_ff <= nxt_bit;
      shr_ff <= nxt_shr;
      clk_oe_ff <= nxt_clk_oe;
      dat_oe_ff <= nxt_dat_oe;
      dat_out_ff <= nxt_dat_out;
      tx_ack_tgl_ff <= nxt_tx_ack_tgl;
      rx_tgl_ff <= nxt_rx_tgl;
      rx_byte_ff <= nxt_rx_byte;
    end
  end

  // Open drain: the clock pin only ever pulls low
  assign ps2_clk_out = 1'b0;
  assign ps2_clk_oe = clk_oe_ff;
  assign ps2_data_out = dat_out_ff;
  assign ps2_data_oe = dat_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: scan buffer, command decode, transmit launch

  typedef enum logic [1:0] {C_CMD, C_LED_ARG, C_RATE_ARG} ps2kb_cstate_type;

  logic buf_valid, buf_pop;
  logic [7:0] buf_data;
  ps2kb_cstate_type cst_ff, nxt_cst;
  logic rx_seen_ff, nxt_rx_seen;
  logic reply_vld_ff, nxt_reply_vld;
  logic [7:0] reply_ff, nxt_reply;
  logic [7:0] last_scan_ff, nxt_last_scan;
  ps2kb_pkg::ps2kb_led_type led_ff, nxt_led;
  logic [7:0] rate_ff, nxt_rate;
  logic kbd_reset_ff, nxt_kbd_reset;
  logic nxt_tx_req_tgl;
  logic [7:0] nxt_tx_word;
  logic rx_new, tx_idle, new_reply;
  logic [7:0] new_reply_byte;

  // A stalled link backs up into the buffer and then onto scan_ready
  ps2kb_buf #(.WIDTH(8), .DEPTH(2)) u_scan_buf (
    .clk(core_clk),
    .rstn(rstn),
    .in_valid(scan_valid),
    .in_data(scan_data),
    .in_ready(scan_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  assign rx_new = (rx_tgl_s != rx_seen_ff);
  assign tx_idle = (tx_ack_s == tx_req_tgl_ff);
  assign buf_pop = tx_idle && !reply_vld_ff && !kbd_reset_ff;

  always_comb begin
    nxt_cst = cst_ff;
    nxt_rx_seen = rx_tgl_s;
    nxt_led = led_ff;
    nxt_rate = rate_ff;
    nxt_kbd_reset = 1'b0;
    nxt_last_scan = last_scan_ff;
    nxt_tx_req_tgl = tx_req_tgl_ff;
    nxt_tx_word = tx_word_ff;
    new_reply = 1'b0;
    new_reply_byte = ps2kb_pkg::REPLY_ACK;
    if (rx_new) begin
      case (cst_ff)
        C_LED_ARG: begin
          nxt_led = '{caps_lock: rx_byte_ff[2], num_lock: rx_byte_ff[1],
                      scroll_lock: rx_byte_ff[0]};
          nxt_cst = C_CMD;
        end
        C_RATE_ARG: begin
          nxt_rate = rx_byte_ff;
          nxt_cst = C_CMD;
        end
        default: begin
          case (rx_byte_ff)
            ps2kb_pkg::CMD_LED: begin
              new_reply = 1'b1;
              nxt_cst = C_LED_ARG;
            end
            ps2kb_pkg::CMD_ECHO: begin
              new_reply = 1'b1;
              new_reply_byte = ps2kb_pkg::CMD_ECHO;
            end
            ps2kb_pkg::CMD_RATE: begin
              new_reply = 1'b1;
              nxt_cst = C_RATE_ARG;
            end
            ps2kb_pkg::CMD_RESEND: begin
              new_reply = 1'b1;
              new_reply_byte = last_scan_ff;
            end
            ps2kb_pkg::CMD_RESET: begin
              nxt_kbd_reset = 1'b1;
              nxt_led = ps2kb_pkg::LED_RST;
              nxt_rate = ps2kb_pkg::RATE_RST;
              nxt_last_scan = ps2kb_pkg::LAST_SCAN_RST;
            end
            default: begin
              nxt_cst = C_CMD;
            end
          endcase
        end
      endcase
    end
    // A reply raised this cycle survives a launch of the older one
    nxt_reply_vld = reply_vld_ff;
    nxt_reply = reply_ff;
    if (tx_idle && reply_vld_ff) begin
      nxt_tx_word = reply_ff;
      nxt_tx_req_tgl = ~tx_req_tgl_ff;
      nxt_reply_vld = 1'b0;
    end else if (buf_valid && buf_pop) begin
      nxt_tx_word = buf_data;
      nxt_tx_req_tgl = ~tx_req_tgl_ff;
      nxt_last_scan = buf_data;
    end
    if (new_reply) begin
      nxt_reply_vld = 1'b1;
      nxt_reply = new_reply_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cst_ff <= C_CMD;
      rx_seen_ff <= 1'b0;
      reply_vld_ff <= 1'b0;
      reply_ff <= ps2kb_pkg::REPLY_ACK;
      last_scan_ff <= ps2kb_pkg::LAST_SCAN_RST;
      led_ff <= ps2kb_pkg::LED_RST;
      rate_ff <= ps2kb_pkg::RATE_RST;
      kbd_reset_ff <= 1'b0;
      tx_req_tgl_ff <= 1'b0;
      tx_word_ff <= '0;
    end else begin
      cst_ff <= nxt_cst;
      rx_seen_ff <= nxt_rx_seen;
      reply_vld_ff <= nxt_reply_vld;
      reply_ff <= nxt_reply;
      last_scan_ff <= nxt_last_scan;
      led_ff <= nxt_led;
      rate_ff <= nxt_rate;
      kbd_reset_ff <= nxt_kbd_reset;
      tx_req_tgl_ff <= nxt_tx_req_tgl;
      tx_word_ff <= nxt_tx_word;
    end
  end

  assign led_state = led_ff;
  assign repeat_rate = rate_ff;
  assign kbd_reset = kbd_reset_ff;

endmodule

// ===== dv/ps2kb_link_monitor.sv
// Checker for ps2kb_link, attached by bind to its ports.
// Assumes the ps2 inputs carry the resolved open-drain wire levels.
module ps2kb_link_monitor #(
  parameter logic [11:0] HALF_BIT_CYC = ps2kb_pkg::HALF_BIT_CYC,
  parameter logic [11:0] IDLE_CYC = ps2kb_pkg::IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic ps2_clk_in,
  input wire logic ps2_clk_oe,
  input wire logic ps2_data_in,
  input wire logic ps2_data_out,
  input wire logic ps2_data_oe,
  input wire ps2kb_pkg::ps2kb_led_type led_state,
  input wire logic [7:0] repeat_rate,
  input wire logic kbd_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] low_cnt_ff, nxt_low_cnt, idle_cnt_ff, nxt_idle_cnt;
  logic [3:0] pulse_cnt_ff, nxt_pulse_cnt;
  logic oe_q_ff, host_req_ff, nxt_host_req;

  ////////////////////////////////////////////////////////////////
  // Pulse count is spoiled to F when the host pulls clock mid-frame
  always_comb begin
    nxt_low_cnt = ps2_clk_oe ? low_cnt_ff + 12'h001 : 12'h000;
    nxt_idle_cnt = idle_cnt_ff;
    if (!ps2_clk_in || !ps2_data_in) nxt_idle_cnt = 12'h000;
    else if (idle_cnt_ff != 12'hFFF) nxt_idle_cnt = idle_cnt_ff + 12'h001;
    nxt_host_req = host_req_ff;
    if (ps2_clk_in && !ps2_data_in && !ps2_data_oe && !ps2_clk_oe) nxt_host_req = 1'b1;
    else if (idle_cnt_ff > HALF_BIT_CYC + 12'h002) nxt_host_req = 1'b0;
    nxt_pulse_cnt = pulse_cnt_ff;
    if (!ps2_data_oe) nxt_pulse_cnt = 4'h0;
    else if (!ps2_clk_in && !ps2_clk_oe) nxt_pulse_cnt = 4'hF;
    else if (ps2_clk_oe && !oe_q_ff && pulse_cnt_ff != 4'hF) nxt_pulse_cnt = pulse_cnt_ff + 4'h1;
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_ff <= 12'h000;
      idle_cnt_ff <= 12'h000;
      pulse_cnt_ff <= 4'h0;
      oe_q_ff <= 1'b0;
      host_req_ff <= 1'b0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
      idle_cnt_ff <= nxt_idle_cnt;
      pulse_cnt_ff <= nxt_pulse_cnt;
      oe_q_ff <= ps2_clk_oe;
      host_req_ff <= nxt_host_req;
    end
  end

  idle_before_start_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(ps2_data_oe) && !host_req_ff |-> idle_cnt_ff >= IDLE_CYC)
    else $error("frame started without idle lines");
  start_bit_low_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(ps2_data_oe) && !host_req_ff |-> !ps2_data_out && !ps2_clk_oe)
    else $error("frame did not open with a low start bit");
  low_phase_len_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(ps2_clk_oe) |-> low_cnt_ff == HALF_BIT_CYC)
    else $error("clock low phase has wrong length");
  pulse_count_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(ps2_data_oe) && !host_req_ff |-> pulse_cnt_ff == 4'hB || pulse_cnt_ff == 4'hF)
    else $error("frame did not carry eleven clock pulses");
  data_steady_a: assert property (@(posedge link_clk) disable iff (!rstn)
    ps2_clk_oe && $past(ps2_clk_oe) && ps2_data_oe && $past(ps2_data_oe) |-> $stable(ps2_data_out))
    else $error("data moved while clock was low");
  data_at_fall_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(ps2_clk_oe) && ps2_data_oe && !host_req_ff |-> $stable(ps2_data_out))
    else $error("data moved at the falling clock edge");
  release_idle_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(ps2_data_oe) |-> !ps2_clk_oe [*8])
    else $error("clock still pulled after data release");
  clock_in_frame_a: assert property (@(posedge link_clk) disable iff (!rstn)
    ps2_clk_oe |-> ps2_data_oe || host_req_ff)
    else $error("clock pulled outside any frame");
  reset_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    kbd_reset |=> !kbd_reset && led_state == ps2kb_pkg::LED_RST
      && repeat_rate == ps2kb_pkg::RATE_RST)
    else $error("keyboard reset pulse or state clear wrong");
endmodule

bind ps2kb_link ps2kb_link_monitor #(.HALF_BIT_CYC(HALF_BIT_CYC), .IDLE_CYC(IDLE_CYC)) u_monitor (
  .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .ps2_clk_in(ps2_clk_in),
  .ps2_clk_oe(ps2_clk_oe), .ps2_data_in(ps2_data_in), .ps2_data_out(ps2_data_out),
  .ps2_data_oe(ps2_data_oe), .led_state(led_state), .repeat_rate(repeat_rate),
  .kbd_reset(kbd_reset)
);

// ===== dv/ps2kb_host_model.sv
// Host end of the link: pull-ups, frame capture and command sending.
// Assumes open-drain keyboard pins; the host only ever pulls lines low.
module ps2kb_host_model #(
  parameter int HALF_CYC = int'(ps2kb_pkg::HALF_BIT_CYC)
) (
  input wire logic clk_oe,
  input wire logic clk_out,
  input wire logic data_oe,
  input wire logic data_out,
  output logic clk_wire,
  output logic data_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock period on the wire, in ns
  localparam realtime BIT_NS = 2.0 * HALF_CYC * ps2kb_pkg::LINK_CLK_PS / 1000.0;
  logic host_clk_low = 1'b0;
  logic host_data_low = 1'b0;
  logic sending = 1'b0;
  logic ack_seen = 1'b0;
  logic rx_ok = 1'b0;
  logic [10:0] rx_sr = 11'h000;
  logic [7:0] rx_byte = 8'h00;
  int rx_bits = 0;
  int rx_frames = 0;
  int period_errs = 0;
  realtime last_fall = 0;

  ////////////////////////////////////////////////////////////////
  // Released lines float back up through the pull-ups
  assign clk_wire = !((clk_oe && !clk_out) || host_clk_low);
  assign data_wire = !((data_oe && !data_out) || host_data_low);

  // Sample on the falling clock edge
  always @(negedge clk_wire) begin
    if (!sending && !host_clk_low) begin
      if (rx_bits > 0 && ($realtime - last_fall < BIT_NS - 1.0 ||
          $realtime - last_fall > BIT_NS + 1.0))
        period_errs++;
      last_fall = $realtime;
      rx_sr = {data_wire, rx_sr[10:1]};
      rx_bits++;
      if (rx_bits == 11) begin
        rx_byte = rx_sr[8:1];
        rx_ok = !rx_sr[0] && rx_sr[10] && ^rx_sr[9:1];
        rx_bits = 0;
        rx_frames++;
      end
    end
  end

  // Request with data low and clock high; bits change only while clock is low
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] bits;
    bits = {1'b1, ~^b, b};
    sending = 1'b1;
    host_data_low = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_wire);
      host_data_low = !bits[i];
    end
    @(negedge clk_wire);
    #(BIT_NS / 4);
    ack_seen = !data_wire;
    @(posedge clk_wire);
    sending = 1'b0;
  endtask
endmodule

// ===== dv/test_ps2_keyboard_link.sv
// Self-checking bench for ps2kb_link with a behavioural host on the wire.
// Assumes the package constants; link timing is shortened so a frame is about 1200 core cycles.
module test_ps2_keyboard_link;
  timeunit 1ns;
  timeprecision 1ps;
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
  localparam int WAIT_LIM = 5000;
  localparam int RUN_LIM = 90000;
  // Short link halves keep the run small; the host's period check follows them
  localparam logic [11:0] HALF_CYC = 12'h010;
  localparam logic [11:0] IDLE_CYC = 12'h030;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic scan_valid = 1'b0;
  logic [7:0] scan_data = 8'h00;
  logic scan_ready, clk_out, clk_oe, data_out, data_oe, kbd_reset, clk_wire, data_wire;
  logic [7:0] repeat_rate;
  ps2kb_pkg::ps2kb_led_type led_state;
  int n_errors = 0;
  int check_count = 0;
  int saw_full = 0;

  ps2kb_link #(.HALF_BIT_CYC(HALF_CYC), .IDLE_CYC(IDLE_CYC)) DUT (
    .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk),
    .scan_valid(scan_valid), .scan_data(scan_data), .scan_ready(scan_ready),
    .ps2_clk_in(clk_wire), .ps2_clk_out(clk_out), .ps2_clk_oe(clk_oe),
    .ps2_data_in(data_wire), .ps2_data_out(data_out), .ps2_data_oe(data_oe),
    .led_state(led_state), .repeat_rate(repeat_rate), .kbd_reset(kbd_reset));
  ps2kb_host_model #(.HALF_CYC(HALF_CYC)) host (.clk_oe(clk_oe), .clk_out(clk_out),
    .data_oe(data_oe),
    .data_out(data_out), .clk_wire(clk_wire), .data_wire(data_wire));

  initial begin
    forever #2.5 core_clk = !core_clk;
  end
  // Odd offset keeps the link clock out of phase with the core clock
  initial begin
    #3.3;
    forever #7.5 link_clk = !link_clk;
  end
  always @(posedge core_clk) if (scan_valid && scan_ready === 1'b0) saw_full = 1;

  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    $display("[ERR] %0t wait limit reached", $time);
    final_report();
  endtask
  task automatic push(input logic [7:0] b);
    int i;
    i = 0;
    @(posedge core_clk);
    scan_valid <= 1'b1;
    scan_data <= b;
    do begin
      @(posedge core_clk);
      i++;
    end while (scan_ready !== 1'b1 && i < WAIT_LIM);
    scan_valid <= 1'b0;
    if (i >= WAIT_LIM) timeout();
  endtask
  // Waits for one frame at the host, then for data_oe to drop, and checks that both lines are released
  task automatic wait_frame(input logic [7:0] exp);
    int start, i;
    start = host.rx_frames;
    for (i = 0; i < WAIT_LIM && host.rx_frames == start; i++) @(posedge core_clk);
    if (i >= WAIT_LIM) timeout();
    `CHECK(host.rx_byte, exp);
    `CHECK(host.rx_ok, 1'b1);
    for (i = 0; i < 5000 && data_oe !== 1'b0; i++) @(posedge core_clk);
    `CHECK({clk_oe, data_oe, clk_wire, data_wire}, 4'h3);
  endtask
  task automatic send_arg(input logic [7:0] cmd, input logic [7:0] arg);
    host.send_byte(cmd);
    wait_frame(ps2kb_pkg::REPLY_ACK);
    host.send_byte(arg);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    `CHECK({clk_oe, data_oe, kbd_reset, scan_ready}, 4'h1);
    `CHECK(led_state, ps2kb_pkg::LED_RST);
    `CHECK(repeat_rate, ps2kb_pkg::RATE_RST);
  endtask
  // Host blocks the link while four bytes queue up, so the buffer must refuse
  task automatic test_inhibit_fill();
    int busy;
    busy = 0;
    fork
      begin
        host.host_clk_low = 1'b1;
        repeat (2000) begin
          @(posedge core_clk);
          busy += int'(data_oe !== 1'b0);
        end
        host.host_clk_low = 1'b0;
      end
      begin
        push(8'h1C);
        push(8'h32);
        push(8'h5A);
        push(8'hF0);
      end
    join
    `CHECK(busy, 0);
    `CHECK(saw_full, 1);
    // The last byte is only taken once the first frame is out, so it is already here
    `CHECK(host.rx_frames, 1);
    `CHECK(host.rx_byte, 8'h1C);
    `CHECK(host.rx_ok, 1'b1);
    wait_frame(8'h32);
    wait_frame(8'h5A);
    wait_frame(8'hF0);
    `CHECK(host.period_errs, 0);
  endtask
  task automatic test_resend();
    host.send_byte(ps2kb_pkg::CMD_RESEND);
    wait_frame(8'hF0);
  endtask
  task automatic test_echo();
    host.send_byte(ps2kb_pkg::CMD_ECHO);
    `CHECK(host.ack_seen, 1'b1);
    wait_frame(ps2kb_pkg::CMD_ECHO);
  endtask
  task automatic test_led();
    int i;
    send_arg(ps2kb_pkg::CMD_LED, 8'hFD);
    for (i = 0; i < 2000 && led_state !== 3'h5; i++) @(posedge core_clk);
    `CHECK(led_state, 3'h5);
  endtask
  task automatic test_rate();
    int i;
    send_arg(ps2kb_pkg::CMD_RATE, 8'h2B);
    for (i = 0; i < 2000 && repeat_rate !== 8'h2B; i++) @(posedge core_clk);
    `CHECK(repeat_rate, 8'h2B);
  endtask
  task automatic test_reset_cmd();
    int i;
    host.send_byte(ps2kb_pkg::CMD_RESET);
    for (i = 0; i < 2000 && kbd_reset !== 1'b1; i++) @(posedge core_clk);
    `CHECK(kbd_reset, 1'b1);
    @(posedge core_clk);
    #1;
    `CHECK({led_state, repeat_rate}, {ps2kb_pkg::LED_RST, ps2kb_pkg::RATE_RST});
  endtask

  initial begin
    repeat (RUN_LIM) @(posedge core_clk);
    timeout();
  end
  // Reset is asynchronous, so three core cycles also clear the link side
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    test_reset_values();
    test_inhibit_fill();
    test_resend();
    test_echo();
    test_led();
    test_rate();
    test_reset_cmd();
    final_report();
  end
endmodule
